/* cqs_dev.sv */
`include "cqs_cfg.svh"

module cqs_dev (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Probed design
    input wire logic [`CQS_SW-1:0] probe,
    input wire logic trig_event,
    // Capture buffer write port
    output logic buf_we,
    output logic [`CQS_AW-1:0] buf_addr,
    output logic [`CQS_SW-1:0] buf_data,
    // Host link
    cqs_if.dev link
);

    function automatic logic qual_eval(
        input logic [`CQS_NPROBE-1:0] hit,
        input logic [`CQS_NPROBE-1:0] en,
        input cqs_pkg::cqs_op_e op
    );
        logic all_hit;
        logic any_hit;
        all_hit = &(hit | ~en);
        any_hit = |(hit & en);
        case (op)
            cqs_pkg::CQS_AND: qual_eval = all_hit;
            cqs_pkg::CQS_OR: qual_eval = any_hit;
            cqs_pkg::CQS_NAND: qual_eval = ~all_hit;
            cqs_pkg::CQS_NOR: qual_eval = ~any_hit;
            default: qual_eval = 1'b0;
        endcase
    endfunction : qual_eval

    function automatic logic [`CQS_AW-1:0] depth_mask(
        input logic [`CQS_LW-1:0] lg
    );
        logic [`CQS_AW:0] one_hot;
        one_hot = (`CQS_AW+1)'(1) << lg;
        depth_mask = `CQS_AW'(one_hot - (`CQS_AW+1)'(1));
    endfunction : depth_mask

    function automatic logic [`CQS_AW-1:0] win_addr(
        input logic [`CQS_MW-1:0] win,
        input logic [`CQS_LW-1:0] lg,
        input logic [`CQS_AW-1:0] ptr
    );
        logic [`CQS_AW-1:0] base;
        base = `CQS_AW'({1'b0, win} << lg);
        win_addr = base | ptr;
    endfunction : win_addr

    // Capture control state
    cqs_pkg::cqs_state_e state_q, state_d;
    logic [`CQS_AW-1:0] ptr_q, ptr_d;
    logic [`CQS_MW-1:0] win_q, win_d;
    logic [`CQS_MW-1:0] last_win_q, last_win_d;
    logic [`CQS_LW-1:0] dlog_q, dlog_d;
    logic [`CQS_AW-1:0] tpos_q, tpos_d;
    logic mode_q, mode_d;
    cqs_pkg::cqs_op_e op_q, op_d;
    logic [`CQS_NPROBE-1:0] en_q, en_d;
    logic [`CQS_SW-1:0] val_q, val_d;
    logic full_q, full_d;
    logic [`CQS_AW-1:0] done_q, done_d;
    // Buffer write port registers
    logic we_q, we_d;
    logic [`CQS_AW-1:0] addr_q, addr_d;
    logic [`CQS_SW-1:0] data_q, data_d;
    // Trigger marks
    logic [`CQS_AW-1:0] mark_mem [0:(1<<`CQS_MW)-1];
    logic mark_we;
    logic [`CQS_AW-1:0] mark_wval;
    logic [`CQS_AW-1:0] mark_q;

    logic [`CQS_NPROBE-1:0] hit;
    logic qual;
    logic capturing;
    logic store;
    logic win_end;
    logic [`CQS_LW-1:0] cfg_wlog;
    logic [`CQS_LW-1:0] cfg_dlog;
    logic [`CQS_LW:0] dlog_room;
    logic [`CQS_AW-1:0] cfg_tpos;
    logic [`CQS_AW-1:0] mask;
    logic [`CQS_AW-1:0] cur_addr;

    // Probe comparators and qualifier
    always_comb begin
        for (int i = 0; i < `CQS_NPROBE; i++) begin
            hit[i] = probe[i*`CQS_PW +: `CQS_PW] == val_q[i*`CQS_PW +: `CQS_PW];
        end
        qual = qual_eval(hit, en_q, op_q);
    end

    // Window geometry clamped to the buffer share
    always_comb begin
        cfg_wlog = link.win_log2;
        if (link.win_log2 > `CQS_LW'(`CQS_MW)) begin
            cfg_wlog = `CQS_LW'(`CQS_MW);
        end
        dlog_room = (`CQS_LW+1)'(`CQS_AW) - {1'b0, cfg_wlog};
        cfg_dlog = link.depth_log2;
        if ({1'b0, link.depth_log2} > dlog_room) begin
            cfg_dlog = dlog_room[`CQS_LW-1:0];
        end
        cfg_tpos = link.trig_pos & depth_mask(cfg_dlog);
    end

    assign mask = depth_mask(dlog_q);
    assign cur_addr = win_addr(win_q, dlog_q, ptr_q);
    assign capturing = state_q != cqs_pkg::CQS_IDLE;

    // Store decision; waiting stores only the trigger sample
    always_comb begin
        store = capturing && !link.stop;
        if (mode_q && !qual) begin
            store = 1'b0;
        end
        if (state_q == cqs_pkg::CQS_WAIT && !trig_event) begin
            store = 1'b0;
        end
        if (state_q == cqs_pkg::CQS_PRE || state_q == cqs_pkg::CQS_POST) begin
            win_end = store && ptr_q == mask;
        end else begin
            win_end = store && ptr_q == mask && trig_event;
        end
        if (state_q == cqs_pkg::CQS_PRE) begin
            win_end = 1'b0;
        end
    end

    // Capture sequencing
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        win_d = win_q;
        last_win_d = last_win_q;
        dlog_d = dlog_q;
        tpos_d = tpos_q;
        mode_d = mode_q;
        op_d = op_q;
        en_d = en_q;
        val_d = val_q;
        full_d = full_q;
        done_d = done_q;
        mark_we = 1'b0;
        mark_wval = cur_addr;
        we_d = store;
        addr_d = cur_addr;
        data_d = probe;
        if (store) begin
            ptr_d = ptr_q + `CQS_AW'(1);
        end
        case (state_q)
            cqs_pkg::CQS_IDLE: begin
                if (link.run) begin
                    win_d = `CQS_WIN_RST;
                    ptr_d = `CQS_PTR_RST;
                    done_d = `CQS_CNT_RST;
                    full_d = 1'b0;
                    last_win_d = `CQS_MW'(({`CQS_MW'(0), 1'b1} << cfg_wlog) - 1);
                    dlog_d = cfg_dlog;
                    tpos_d = cfg_tpos;
                    mode_d = link.mode_qual;
                    op_d = link.qual_op;
                    en_d = link.cmp_en;
                    val_d = link.cmp_val;
                    if (cfg_tpos == `CQS_PTR_RST) begin
                        state_d = cqs_pkg::CQS_WAIT;
                    end else begin
                        state_d = cqs_pkg::CQS_PRE;
                    end
                end
            end
            cqs_pkg::CQS_PRE: begin
                if (store && ptr_d == tpos_q) begin
                    state_d = cqs_pkg::CQS_WAIT;
                end
            end
            cqs_pkg::CQS_WAIT: begin
                if (trig_event && !link.stop) begin
                    mark_we = 1'b1;
                    state_d = cqs_pkg::CQS_POST;
                end
            end
            cqs_pkg::CQS_POST: begin
            end
            default: begin
                state_d = cqs_pkg::CQS_IDLE;
            end
        endcase
        if (win_end) begin
            done_d = done_q + `CQS_AW'(1);
            ptr_d = `CQS_PTR_RST;
            if (win_q == last_win_q) begin
                full_d = 1'b1;
                state_d = cqs_pkg::CQS_IDLE;
            end else begin
                win_d = win_q + `CQS_MW'(1);
                if (tpos_q == `CQS_PTR_RST) begin
                    state_d = cqs_pkg::CQS_WAIT;
                end else begin
                    state_d = cqs_pkg::CQS_PRE;
                end
            end
        end
        if (link.stop && capturing) begin
            state_d = cqs_pkg::CQS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= cqs_pkg::CQS_IDLE;
            ptr_q <= `CQS_PTR_RST;
            win_q <= `CQS_WIN_RST;
            last_win_q <= `CQS_WIN_RST;
            dlog_q <= `CQS_LOG_RST;
            tpos_q <= `CQS_PTR_RST;
            mode_q <= 1'b0;
            op_q <= cqs_pkg::CQS_AND;
            en_q <= `CQS_EN_RST;
            val_q <= `CQS_VAL_RST;
            full_q <= 1'b0;
            done_q <= `CQS_CNT_RST;
            we_q <= 1'b0;
            addr_q <= `CQS_PTR_RST;
            data_q <= `CQS_VAL_RST;
            mark_q <= `CQS_PTR_RST;
        end else if (ce) begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            win_q <= win_d;
            last_win_q <= last_win_d;
            dlog_q <= dlog_d;
            tpos_q <= tpos_d;
            mode_q <= mode_d;
            op_q <= op_d;
            en_q <= en_d;
            val_q <= val_d;
            full_q <= full_d;
            done_q <= done_d;
            we_q <= we_d;
            addr_q <= addr_d;
            data_q <= data_d;
            mark_q <= mark_mem[link.mark_sel];
        end
    end

    // Mark memory, no reset
    always_ff @(posedge clk) begin
        if (ce && mark_we && !reset) begin
            mark_mem[win_q] <= mark_wval;
        end
    end

    assign buf_we = we_q;
    assign buf_addr = addr_q;
    assign buf_data = data_q;
    assign link.state = state_q;
    assign link.full = full_q;
    assign link.win_done = done_q;
    assign link.mark_val = mark_q;

endmodule : cqs_dev

/* cqs_cfg.svh */
`ifndef CQS_CFG_SVH
`define CQS_CFG_SVH

// Capture buffer address width (1024 samples)
`define CQS_AW 10
// Trigger mark memory index width (at most half the buffer as windows)
`define CQS_MW 9
// Probe comparators and their width
`define CQS_NPROBE 4
`define CQS_PW 8
// Sample width, all probes concatenated
`define CQS_SW 32
// Width of the log2 window count and window depth fields
`define CQS_LW 4

// Reset values
`define CQS_PTR_RST 10'h000
`define CQS_WIN_RST 9'h000
`define CQS_CNT_RST 10'h000
`define CQS_LOG_RST 4'h0
`define CQS_EN_RST 4'h0
`define CQS_VAL_RST 32'h0000_0000

`endif

/* cqs_pkg.sv */
`include "cqs_cfg.svh"

package cqs_pkg;

    typedef enum logic [1:0] {
        CQS_IDLE = 2'b00,
        CQS_PRE = 2'b01,
        CQS_WAIT = 2'b10,
        CQS_POST = 2'b11
    } cqs_state_e;

    typedef enum logic [1:0] {
        CQS_AND = 2'b00,
        CQS_OR = 2'b01,
        CQS_NAND = 2'b10,
        CQS_NOR = 2'b11
    } cqs_op_e;

    typedef enum logic [1:0] {
        CQS_H_IDLE = 2'b00,
        CQS_H_ARM = 2'b01,
        CQS_H_RUN = 2'b10,
        CQS_H_DONE = 2'b11
    } cqs_hstate_e;

endpackage : cqs_pkg

/* cqs_if.sv */
`include "cqs_cfg.svh"

interface cqs_if;
    // Commands, one-cycle pulses from host
    logic run;
    logic stop;
    // Capture configuration from host
    logic mode_qual;
    cqs_pkg::cqs_op_e qual_op;
    logic [`CQS_NPROBE-1:0] cmp_en;
    logic [`CQS_SW-1:0] cmp_val;
    logic [`CQS_LW-1:0] win_log2;
    logic [`CQS_LW-1:0] depth_log2;
    logic [`CQS_AW-1:0] trig_pos;
    logic [`CQS_MW-1:0] mark_sel;
    // Status from device
    cqs_pkg::cqs_state_e state;
    logic full;
    logic [`CQS_AW-1:0] win_done;
    logic [`CQS_AW-1:0] mark_val;

    modport dev (
        input run, stop, mode_qual, qual_op, cmp_en, cmp_val,
        input win_log2, depth_log2, trig_pos, mark_sel,
        output state, full, win_done, mark_val
    );

    modport host (
        output run, stop, mode_qual, qual_op, cmp_en, cmp_val,
        output win_log2, depth_log2, trig_pos, mark_sel,
        input state, full, win_done, mark_val
    );
endinterface : cqs_if

/* cqs_host.sv */
`include "cqs_cfg.svh"

module cqs_host (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Commands
    input wire logic cmd_start,
    input wire logic cmd_stop,
    // Configuration
    input wire logic cfg_qual,
    input wire cqs_pkg::cqs_op_e cfg_op,
    input wire logic [`CQS_NPROBE-1:0] cfg_en,
    input wire logic [`CQS_SW-1:0] cfg_val,
    input wire logic [`CQS_LW-1:0] cfg_win_log2,
    input wire logic [`CQS_LW-1:0] cfg_depth_log2,
    input wire logic [`CQS_AW-1:0] cfg_tpos,
    input wire logic [`CQS_MW-1:0] cfg_mark_sel,
    // Status
    output logic busy,
    output logic upload_ready,
    output logic cfg_reject,
    output logic [`CQS_AW-1:0] windows_done,
    output logic [`CQS_AW-1:0] mark_value,
    // Device link
    cqs_if.host link
);

    cqs_pkg::cqs_hstate_e hs_q, hs_d;
    logic run_q, run_d;
    logic stop_q, stop_d;
    logic rej_q, rej_d;
    logic qual_q, qual_d;
    cqs_pkg::cqs_op_e op_q, op_d;
    logic [`CQS_NPROBE-1:0] en_q, en_d;
    logic [`CQS_SW-1:0] val_q, val_d;
    logic [`CQS_LW-1:0] wlog_q, wlog_d;
    logic [`CQS_LW-1:0] dlog_q, dlog_d;
    logic [`CQS_AW-1:0] tpos_q, tpos_d;
    logic [`CQS_LW:0] span;
    logic cfg_ok;

    // Geometry check before a run
    always_comb begin
        span = {1'b0, cfg_win_log2} + {1'b0, cfg_depth_log2};
        cfg_ok = cfg_win_log2 <= `CQS_LW'(`CQS_MW)
            && span <= (`CQS_LW+1)'(`CQS_AW)
            && ({1'b0, cfg_tpos} >> cfg_depth_log2) == '0;
    end

    always_comb begin
        hs_d = hs_q;
        run_d = 1'b0;
        stop_d = 1'b0;
        rej_d = 1'b0;
        qual_d = qual_q;
        op_d = op_q;
        en_d = en_q;
        val_d = val_q;
        wlog_d = wlog_q;
        dlog_d = dlog_q;
        tpos_d = tpos_q;
        case (hs_q)
            cqs_pkg::CQS_H_IDLE, cqs_pkg::CQS_H_DONE: begin
                if (cmd_start && cfg_ok) begin
                    qual_d = cfg_qual;
                    op_d = cfg_op;
                    en_d = cfg_en;
                    val_d = cfg_val;
                    wlog_d = cfg_win_log2;
                    dlog_d = cfg_depth_log2;
                    tpos_d = cfg_tpos;
                    run_d = 1'b1;
                    hs_d = cqs_pkg::CQS_H_ARM;
                end else if (cmd_start) begin
                    rej_d = 1'b1;
                end
            end
            cqs_pkg::CQS_H_ARM: begin
                hs_d = cqs_pkg::CQS_H_RUN;
            end
            cqs_pkg::CQS_H_RUN: begin
                if (cmd_stop) begin
                    stop_d = 1'b1;
                    hs_d = cqs_pkg::CQS_H_DONE;
                end else if (link.state == cqs_pkg::CQS_IDLE) begin
                    hs_d = cqs_pkg::CQS_H_DONE;
                end
            end
            default: begin
                hs_d = cqs_pkg::CQS_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hs_q <= cqs_pkg::CQS_H_IDLE;
            run_q <= 1'b0;
            stop_q <= 1'b0;
            rej_q <= 1'b0;
            qual_q <= 1'b0;
            op_q <= cqs_pkg::CQS_AND;
            en_q <= `CQS_EN_RST;
            val_q <= `CQS_VAL_RST;
            wlog_q <= `CQS_LOG_RST;
            dlog_q <= `CQS_LOG_RST;
            tpos_q <= `CQS_PTR_RST;
        end else if (ce) begin
            hs_q <= hs_d;
            run_q <= run_d;
            stop_q <= stop_d;
            rej_q <= rej_d;
            qual_q <= qual_d;
            op_q <= op_d;
            en_q <= en_d;
            val_q <= val_d;
            wlog_q <= wlog_d;
            dlog_q <= dlog_d;
            tpos_q <= tpos_d;
        end
    end

    assign link.run = run_q;
    assign link.stop = stop_q;
    assign link.mode_qual = qual_q;
    assign link.qual_op = op_q;
    assign link.cmp_en = en_q;
    assign link.cmp_val = val_q;
    assign link.win_log2 = wlog_q;
    assign link.depth_log2 = dlog_q;
    assign link.trig_pos = tpos_q;
    assign link.mark_sel = cfg_mark_sel;
    assign busy = hs_q == cqs_pkg::CQS_H_ARM || hs_q == cqs_pkg::CQS_H_RUN;
    assign upload_ready = hs_q == cqs_pkg::CQS_H_DONE;
    assign cfg_reject = rej_q;
    assign windows_done = link.win_done;
    assign mark_value = link.mark_val;

endmodule : cqs_host

/* capture_qualify_segment_properties.sv */
`include "cqs_cfg.svh"

module cqs_props (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Host side
    input wire logic run,
    input wire logic stop,
    input wire logic [`CQS_AW-1:0] trig_pos,
    input wire logic [`CQS_LW-1:0] win_log2,
    // Device side
    input wire cqs_pkg::cqs_state_e state,
    input wire logic full,
    input wire logic [`CQS_AW-1:0] win_done
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_start;
        ce && run && state == cqs_pkg::CQS_IDLE;
    endsequence

    sequence s_halt;
        ce && stop && state != cqs_pkg::CQS_IDLE;
    endsequence

    a_start_wait: assert property (
        s_start ##0 (trig_pos == 10'h000) |=> state == cqs_pkg::CQS_WAIT)
        else $error("run with zero position did not wait");
    a_start_pre: assert property (
        s_start ##0 (trig_pos != 10'h000) |=> state == cqs_pkg::CQS_PRE)
        else $error("run with position did not prefill");
    a_start_clear: assert property (s_start |=> !full)
        else $error("full not cleared by run");
    a_stop_halt: assert property (s_halt |=> state == cqs_pkg::CQS_IDLE)
        else $error("stop did not halt capture");
    a_full_idle: assert property (full |-> state == cqs_pkg::CQS_IDLE)
        else $error("capturing while full");
    a_pre_no_post: assert property (
        state == cqs_pkg::CQS_PRE |=> state != cqs_pkg::CQS_POST)
        else $error("prefill jumped to post");
    a_post_entry: assert property (
        (state == cqs_pkg::CQS_POST && $past(state) != cqs_pkg::CQS_POST)
        |-> $past(state) == cqs_pkg::CQS_WAIT)
        else $error("post entered without trigger wait");
    a_idle_hold: assert property (
        state == cqs_pkg::CQS_IDLE && !run |=> state == cqs_pkg::CQS_IDLE)
        else $error("left idle without run");
    a_done_step: assert property (
        !$stable(win_done) |->
        win_done == $past(win_done) + 10'h001 || win_done == 10'h000)
        else $error("window count skipped");
    a_full_count: assert property (
        $rose(full) |-> win_done == (10'h001 << win_log2))
        else $error("full before last window");
endmodule : cqs_props

/* capture_qualify_segment_tb.sv */
`include "cqs_cfg.svh"

module capture_qualify_segment_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic qual;
        cqs_pkg::cqs_op_e op;
        logic [3:0] en;
        logic [31:0] val;
        logic [3:0] wl;
        logic [3:0] dl;
        logic [9:0] tp;
    } cqs_row_s;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic cmd_start = 1'b0;
    logic cmd_stop = 1'b0;
    logic trig_event = 1'b0;
    logic [31:0] probe = 32'h0000_0000;
    logic [8:0] msel = 9'h000;
    cqs_row_s cur = '0;
    cqs_row_s rows [6];
    logic buf_we, busy, upload_ready, cfg_reject;
    logic [9:0] buf_addr, windows_done, mark_value;
    logic [9:0] exp_addr = 10'h000;
    logic [31:0] buf_data;
    int cyc = 0;
    int stores = 0;
    int first = 0;
    int last = 0;
    int num_errors = 0;
    int n_compared = 0;

    cqs_if cqs_if_inst ();
    cqs_dev cqs_dev_inst (.clk(clk), .reset(reset), .ce(ce), .probe(probe),
        .trig_event(trig_event), .buf_we(buf_we), .buf_addr(buf_addr),
        .buf_data(buf_data), .link(cqs_if_inst.dev));
    cqs_host cqs_host_inst (.clk(clk), .reset(reset), .ce(ce),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cfg_qual(cur.qual),
        .cfg_op(cur.op), .cfg_en(cur.en), .cfg_val(cur.val),
        .cfg_win_log2(cur.wl), .cfg_depth_log2(cur.dl), .cfg_tpos(cur.tp),
        .cfg_mark_sel(msel), .busy(busy), .upload_ready(upload_ready),
        .cfg_reject(cfg_reject), .windows_done(windows_done),
        .mark_value(mark_value), .link(cqs_if_inst.host));
    cqs_props cqs_props_inst (.clk(clk), .reset(reset), .ce(ce),
        .run(cqs_if_inst.run), .stop(cqs_if_inst.stop),
        .trig_pos(cqs_if_inst.trig_pos), .win_log2(cqs_if_inst.win_log2),
        .state(cqs_if_inst.state), .full(cqs_if_inst.full),
        .win_done(cqs_if_inst.win_done));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // Probe low byte cycles 0..3
    always @(negedge clk) begin
        cyc <= cyc + 1;
        probe <= {30'h0, cyc[1:0]};
    end

    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic qual_exp(input cqs_row_s r,
        input logic [31:0] d);
        logic a;
        logic o;
        a = 1'b1;
        o = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (r.en[i]) begin
                a = a & (d[8*i+:8] == r.val[8*i+:8]);
                o = o | (d[8*i+:8] == r.val[8*i+:8]);
            end
        end
        case (r.op)
            cqs_pkg::CQS_AND: return a;
            cqs_pkg::CQS_OR: return o;
            cqs_pkg::CQS_NAND: return !a;
            default: return !o;
        endcase
    endfunction : qual_exp

    always @(negedge clk) begin
        if (!reset && buf_we === 1'b1) begin
            check("buf_addr", buf_addr, exp_addr);
            if (cur.qual) begin
                check("qualifier", qual_exp(cur, buf_data), 1);
            end
            if (stores == 0) begin
                first = cyc;
            end
            last = cyc;
            stores++;
            exp_addr++;
        end
    end

    task automatic start(input cqs_row_s r);
        cur = r;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        stores = 0;
        exp_addr = 10'h000;
        check("busy", busy, 1'b1);
    endtask : start

    task automatic wait_ready();
        int k;
        k = 0;
        while (upload_ready !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) begin
            num_errors++;
            stop_test();
        end
    endtask : wait_ready

    task automatic mark(input logic [8:0] w, input logic [9:0] e);
        msel = w;
        @(negedge clk);
        @(negedge clk);
        check("mark", mark_value, e);
    endtask : mark

    initial begin
        rows[0] = '{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h1, 4'h2, 10'h000};
        rows[1] = '{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h2, 4'h1, 10'h001};
        rows[2] = '{1'b1, cqs_pkg::CQS_AND, 4'h1, 32'h2, 4'h1, 4'h2, 10'h000};
        rows[3] = '{1'b1, cqs_pkg::CQS_OR, 4'h3, 32'h101, 4'h0, 4'h3, 10'h000};
        rows[4] = '{1'b1, cqs_pkg::CQS_NAND, 4'h3, 32'h2, 4'h1, 4'h2, 10'h002};
        rows[5] = '{1'b1, cqs_pkg::CQS_NOR, 4'h1, 32'h3, 4'h0, 4'h2, 10'h001};
        repeat (6) @(negedge clk);
        reset = 1'b0;
        check("busy", busy, 1'b0);
        check("upload_ready", upload_ready, 1'b0);
        check("buf_we", buf_we, 1'b0);
        check("state", cqs_if_inst.state, cqs_pkg::CQS_IDLE);
        check("windows_done", windows_done, 10'h000);
        // Enable low freezes both ends
        ce = 1'b0;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        ce = 1'b1;
        check("busy", busy, 1'b0);
        check("state", cqs_if_inst.state, cqs_pkg::CQS_IDLE);
        trig_event = 1'b1;
        for (int i = 0; i < 6; i++) begin
            start(rows[i]);
            wait_ready();
            check("stores", stores, 1 << (rows[i].wl + rows[i].dl));
            check("windows", windows_done, 1 << rows[i].wl);
            check("full", cqs_if_inst.full, 1'b1);
            mark(9'h000, rows[i].tp);
            mark((1 << rows[i].wl) - 1,
                (((1 << rows[i].wl) - 1) << rows[i].dl) | rows[i].tp);
            if (!rows[i].qual && rows[i].tp == 10'h000) begin
                check("gap", last - first, stores - 1);
            end
        end
        // Stop after two of four windows
        trig_event = 1'b0;
        start('{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h2, 4'h2, 10'h000});
        for (int j = 0; j < 2; j++) begin
            repeat (3) @(negedge clk);
            trig_event = 1'b1;
            @(negedge clk);
            trig_event = 1'b0;
            repeat (6) @(negedge clk);
        end
        cmd_stop = 1'b1;
        @(negedge clk);
        cmd_stop = 1'b0;
        wait_ready();
        check("windows", windows_done, 10'h002);
        check("stores", stores, 8);
        check("full", cqs_if_inst.full, 1'b0);
        // Trigger during prefill is lost
        trig_event = 1'b1;
        start('{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h0, 4'h2, 10'h003});
        repeat (2) @(negedge clk);
        trig_event = 1'b0;
        repeat (10) @(negedge clk);
        check("state", cqs_if_inst.state, cqs_pkg::CQS_WAIT);
        check("stores", stores, 3);
        trig_event = 1'b1;
        @(negedge clk);
        trig_event = 1'b0;
        wait_ready();
        check("windows", windows_done, 10'h001);
        mark(9'h000, 10'h003);
        // Reset in mid-run returns both ends to idle
        start('{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h0, 4'h2, 10'h000});
        repeat (3) @(negedge clk);
        check("state", cqs_if_inst.state, cqs_pkg::CQS_WAIT);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check("state", cqs_if_inst.state, cqs_pkg::CQS_IDLE);
        check("busy", busy, 1'b0);
        check("upload_ready", upload_ready, 1'b0);
        // Window share overflow refused
        cur = '{1'b0, cqs_pkg::CQS_AND, 4'h0, 32'h0, 4'h9, 4'h2, 10'h000};
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        check("cfg_reject", cfg_reject, 1'b1);
        check("busy", busy, 1'b0);
        // As many windows as samples refused
        @(negedge clk);
        cur.wl = 4'ha;
        cur.dl = 4'h0;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        check("cfg_reject", cfg_reject, 1'b1);
        check("busy", busy, 1'b0);
        stop_test();
    end
endmodule : capture_qualify_segment_tb
